// *** shared/loop_ctrl_pkg.sv ***
package loop_ctrl_pkg;

	// Register indices on the serial configuration port.
	localparam logic [7:0] ADDR_NEAREST_CFG = 8'h03;
	localparam logic [7:0] ADDR_BW_MODE = 8'h3B;
	localparam logic [7:0] ADDR_BUILD_OUT_CTRL = 8'h48;
	localparam logic [7:0] ADDR_MONITOR_SEL = 8'h4B;
	localparam logic [7:0] ADDR_LOCKED_BW = 8'h67;
	localparam logic [7:0] ADDR_ACQ_BW = 8'h69;
	localparam logic [7:0] ADDR_DAMPING = 8'h6B;
	localparam logic [7:0] ADDR_PD2_GAIN = 8'h6D;
	localparam logic [7:0] ADDR_ADJUST_LOW = 8'h70;
	localparam logic [7:0] ADDR_ADJUST_HIGH = 8'h71;
	localparam logic [7:0] ADDR_MEAN_OFFSET = 8'h72;
	localparam logic [7:0] ADDR_FINE_LOSS = 8'h73;
	localparam logic [7:0] ADDR_COARSE_LOSS = 8'h74;
	localparam logic [7:0] ADDR_BUILD_OUT_CTRL2 = 8'h76;
	localparam logic [7:0] ADDR_PHASE_LOW = 8'h77;
	localparam logic [7:0] ADDR_PHASE_HIGH = 8'h78;

	// Field positions.
	localparam int BIT_NEAREST_DIS = 6;
	localparam int BIT_AUTO_BW = 7;
	localparam int BIT_INTEGRAL_LIM = 3;
	localparam int BIT_BO_ENABLE = 3;
	localparam int BIT_BO_FREEZE = 2;
	localparam int BIT_MON_SECONDARY = 4;
	localparam int BIT_PD2_EN = 7;
	localparam int BIT_FINE_EN = 7;
	localparam int BIT_FREQ_LIM_EN = 6;
	localparam int BIT_ACTIVITY_EN = 5;
	localparam int BIT_COARSE_EN = 7;
	localparam int BIT_MULTI_CYCLE = 6;
	localparam int BIT_COARSE_IN_LOOP = 5;
	localparam int BIT_ANTI_NOISE = 7;
	localparam int BIT_BO_OFF2 = 4;

	// Reset values.
	localparam logic [7:0] RST_NEAREST_CFG = 8'h00;
	localparam logic [7:0] RST_BW_MODE = 8'h80;
	localparam logic [7:0] RST_BUILD_OUT_CTRL = 8'h08;
	localparam logic [7:0] RST_MONITOR_SEL = 8'h00;
	localparam logic [7:0] RST_LOCKED_BW = 8'h02;
	localparam logic [7:0] RST_ACQ_BW = 8'h02;
	localparam logic [7:0] RST_DAMPING = 8'h03;
	localparam logic [7:0] RST_PD2_GAIN = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_FINE_LOSS = 8'hE2;
	localparam logic [7:0] RST_COARSE_LOSS = 8'h00;

	// Bandwidth codes: 18, 35 and 70 Hz.
	localparam logic [1:0] BW_18HZ = 2'h0;
	localparam logic [1:0] BW_35HZ = 2'h1;
	localparam logic [1:0] BW_70HZ = 2'h2;

	// Coarse range codes 0 to 12 give 1 to 8191 UI.
	localparam logic [3:0] COARSE_CODE_MAX = 4'hC;

	// Mean offset step is 0.101 ns, limited to 1.4 ns either way.
	localparam real MEAN_STEP_NS = 0.101;
	localparam real MEAN_LIMIT_NS = 1.4;
	localparam logic [5:0] MEAN_LIMIT_STEPS = 6'(int'(MEAN_LIMIT_NS / MEAN_STEP_NS - 0.5));

	// Feedback types for the second phase detector gain choice.
	localparam logic [1:0] FB_DIGITAL = 2'h0;
	localparam logic [1:0] FB_ANALOG_HIGH = 2'h1;
	localparam logic [1:0] FB_ANALOG_8K = 2'h2;

	localparam int LOSS_SOURCES = 4;
	localparam int SRC_FINE = 0;
	localparam int SRC_COARSE = 1;
	localparam int SRC_FREQ_LIMIT = 2;
	localparam int SRC_ACTIVITY = 3;

	typedef enum logic [1:0] {
		BO_IDLE,
		BO_MEASURE
	} build_out_state_t;

endpackage

// *** rtl/loss_combiner.sv ***
`timescale 1ns/1ps
module loss_combiner #(
	parameter int SOURCES = 4
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [SOURCES-1:0] loss_i,
	input wire logic [SOURCES-1:0] enable_i,
	output logic phase_lost_o
);

	logic [SOURCES-1:0] gated;
	logic lost_d;
	logic lost_q;

	genvar g;
	generate
		for (g = 0; g < SOURCES; g++) begin : gen_gate
			assign gated[g] = loss_i[g] & enable_i[g];
		end
	endgenerate

	always_comb begin
		lost_d = |gated;
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			lost_q <= 1'b1;
		end else begin
			lost_q <= lost_d;
		end
	end

	assign phase_lost_o = lost_q;

endmodule // loss_combiner

// *** rtl/loop_lock_build_out.sv ***
`timescale 1ns/1ps
// Operation
// - Four phase-loss sources: fine, coarse slip, frequency limit, no activity, each with its own enable bit.
// - Lock state picks nearest-edge locking and acquisition or locked bandwidth.
// - Nearest-edge locking follows lock only while multi-cycle detector is off.
// - Coarse loss flags a slip of n cycles set by the range field.
// - Coarse loss limit has its own enable; range 1 to 8191 UI.
// - Fine loss limit has its own enable and a 0 to 7 limit.
// - Losing the selected reference picks the next priority input and starts build-out.
// - Build-out holds over, measures input phase, then adds a compensating offset.
// - Build-out is enabled after reset; software enables, disables or freezes it.
// - While frozen no new build-out event starts; one already measuring still sets the offset, and disabling zeroes it.
// - Enabling build-out while locked starts a build-out event.
// - Disabling build-out while locked returns the offset to zero.
// - Six-bit mean offset is added per event, limited to 1.4 ns.
// - Phase adjustment shifts the feedback clock in 6 ps steps, 200 ns range.
// - Phase adjustment applies only with both build-out control bits clear.
// - A bit chooses automatic bandwidth switching or a fixed locked bandwidth.
// - Locked and acquisition bandwidths are 18, 35 or 70 Hz, each own register.
// - Damping factor is chosen by a three-bit field.
// - Multi-cycle phase detector has its own enable bit.
// - An optional bit holds the integral path at the frequency limit.
// - An optional anti-noise filter for low-frequency inputs has its own bit.
// - Second detector gain is picked by feedback type when enabled, else unused.
// - Measured input phase reads as 16 bits; a bit picks primary or secondary.
module loop_lock_build_out #(
	parameter int INPUTS = 3,
	parameter int SEL_W = 2
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] fine_phase_mag_i,
	input wire logic [13:0] slip_cycles_i,
	input wire logic at_freq_limit_i,
	input wire logic input_active_i,
	input wire logic ref_lost_i,
	input wire logic [INPUTS-1:0] input_avail_i,
	input wire logic meas_valid_i,
	input wire logic [15:0] meas_phase_i,
	input wire logic [15:0] primary_phase_i,
	input wire logic [15:0] secondary_phase_i,
	input wire logic [1:0] fb_type_i,
	output logic phase_lost_o,
	output logic nearest_edge_o,
	output logic [1:0] bandwidth_o,
	output logic [2:0] damping_o,
	output logic multi_cycle_o,
	output logic coarse_in_loop_o,
	output logic integral_limit_o,
	output logic anti_noise_o,
	output logic pd2_enable_o,
	output logic [2:0] pd2_gain_o,
	output logic [SEL_W-1:0] sel_input_o,
	output logic holdover_o,
	output logic [15:0] build_out_offset_o,
	output logic [15:0] feedback_adjust_o
);
	import loop_ctrl_pkg::*;

	logic [7:0] nearest_q, nearest_d;
	logic [7:0] bw_mode_q, bw_mode_d;
	logic [7:0] bo_ctrl_q, bo_ctrl_d;
	logic [7:0] mon_sel_q, mon_sel_d;
	logic [7:0] locked_bw_q, locked_bw_d;
	logic [7:0] acq_bw_q, acq_bw_d;
	logic [7:0] damping_q, damping_d;
	logic [7:0] pd2_q, pd2_d;
	logic [7:0] adj_lo_q, adj_lo_d;
	logic [7:0] adj_hi_q, adj_hi_d;
	logic [7:0] mean_q, mean_d;
	logic [7:0] fine_q, fine_d;
	logic [7:0] coarse_q, coarse_d;
	logic [7:0] bo_ctrl2_q, bo_ctrl2_d;
	logic [7:0] rdata_q, rdata_d;
	logic [LOSS_SOURCES-1:0] loss_src;
	logic [LOSS_SOURCES-1:0] loss_en;
	logic lost;
	logic [3:0] coarse_code;
	logic [13:0] coarse_limit;
	logic [15:0] status_phase;
	logic wr_bo;
	logic enable_rise;
	logic disable_fall;
	logic event_req;
	logic [5:0] mean_mag;
	logic [15:0] mean_ext;
	build_out_state_t bo_state_q, bo_state_d;
	logic [SEL_W-1:0] sel_q, sel_d;
	logic [15:0] offset_q, offset_d;
	logic [15:0] adjust_q, adjust_d;
	logic holdover_q, holdover_d;
	logic nearest_out_q, nearest_out_d;
	logic [1:0] bw_q, bw_d;
	logic [2:0] pd2_gain_q, pd2_gain_d;

	// Loss sources and their enables.
	always_comb begin
		coarse_code = (coarse_q[3:0] > COARSE_CODE_MAX) ? COARSE_CODE_MAX : coarse_q[3:0];
		coarse_limit = 14'((15'h0002 << coarse_code) - 15'h0001);
		loss_src[SRC_FINE] = fine_phase_mag_i > {5'h00, fine_q[2:0]};
		loss_src[SRC_COARSE] = slip_cycles_i >= coarse_limit;
		loss_src[SRC_FREQ_LIMIT] = at_freq_limit_i;
		loss_src[SRC_ACTIVITY] = !input_active_i;
		loss_en[SRC_FINE] = fine_q[BIT_FINE_EN];
		loss_en[SRC_COARSE] = coarse_q[BIT_COARSE_EN];
		loss_en[SRC_FREQ_LIMIT] = fine_q[BIT_FREQ_LIM_EN];
		loss_en[SRC_ACTIVITY] = fine_q[BIT_ACTIVITY_EN];
	end

	loss_combiner #(
		.SOURCES(LOSS_SOURCES)
	) u_loss (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.loss_i(loss_src),
		.enable_i(loss_en),
		.phase_lost_o(lost)
	);

	// Register writes and reads.
	always_comb begin
		nearest_d = nearest_q;
		bw_mode_d = bw_mode_q;
		bo_ctrl_d = bo_ctrl_q;
		mon_sel_d = mon_sel_q;
		locked_bw_d = locked_bw_q;
		acq_bw_d = acq_bw_q;
		damping_d = damping_q;
		pd2_d = pd2_q;
		adj_lo_d = adj_lo_q;
		adj_hi_d = adj_hi_q;
		mean_d = mean_q;
		fine_d = fine_q;
		coarse_d = coarse_q;
		bo_ctrl2_d = bo_ctrl2_q;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_NEAREST_CFG: nearest_d = reg_wdata_i;
				ADDR_BW_MODE: bw_mode_d = reg_wdata_i;
				ADDR_BUILD_OUT_CTRL: bo_ctrl_d = reg_wdata_i;
				ADDR_MONITOR_SEL: mon_sel_d = reg_wdata_i;
				ADDR_LOCKED_BW: locked_bw_d = reg_wdata_i;
				ADDR_ACQ_BW: acq_bw_d = reg_wdata_i;
				ADDR_DAMPING: damping_d = reg_wdata_i;
				ADDR_PD2_GAIN: pd2_d = reg_wdata_i;
				ADDR_ADJUST_LOW: adj_lo_d = reg_wdata_i;
				ADDR_ADJUST_HIGH: adj_hi_d = reg_wdata_i;
				ADDR_MEAN_OFFSET: mean_d = reg_wdata_i;
				ADDR_FINE_LOSS: fine_d = reg_wdata_i;
				ADDR_COARSE_LOSS: coarse_d = reg_wdata_i;
				ADDR_BUILD_OUT_CTRL2: bo_ctrl2_d = reg_wdata_i;
				default: begin
				end
			endcase
		end
		status_phase = mon_sel_q[BIT_MON_SECONDARY] ? secondary_phase_i : primary_phase_i;
		rdata_d = rdata_q;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_NEAREST_CFG: rdata_d = nearest_q;
				ADDR_BW_MODE: rdata_d = bw_mode_q;
				ADDR_BUILD_OUT_CTRL: rdata_d = bo_ctrl_q;
				ADDR_MONITOR_SEL: rdata_d = mon_sel_q;
				ADDR_LOCKED_BW: rdata_d = locked_bw_q;
				ADDR_ACQ_BW: rdata_d = acq_bw_q;
				ADDR_DAMPING: rdata_d = damping_q;
				ADDR_PD2_GAIN: rdata_d = pd2_q;
				ADDR_ADJUST_LOW: rdata_d = adj_lo_q;
				ADDR_ADJUST_HIGH: rdata_d = adj_hi_q;
				ADDR_MEAN_OFFSET: rdata_d = mean_q;
				ADDR_FINE_LOSS: rdata_d = fine_q;
				ADDR_COARSE_LOSS: rdata_d = coarse_q;
				ADDR_BUILD_OUT_CTRL2: rdata_d = bo_ctrl2_q;
				ADDR_PHASE_LOW: rdata_d = status_phase[7:0];
				ADDR_PHASE_HIGH: rdata_d = status_phase[15:8];
				default: rdata_d = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			nearest_q <= RST_NEAREST_CFG;
			bw_mode_q <= RST_BW_MODE;
			bo_ctrl_q <= RST_BUILD_OUT_CTRL;
			mon_sel_q <= RST_MONITOR_SEL;
			locked_bw_q <= RST_LOCKED_BW;
			acq_bw_q <= RST_ACQ_BW;
			damping_q <= RST_DAMPING;
			pd2_q <= RST_PD2_GAIN;
			adj_lo_q <= RST_ZERO;
			adj_hi_q <= RST_ZERO;
			mean_q <= RST_ZERO;
			fine_q <= RST_FINE_LOSS;
			coarse_q <= RST_COARSE_LOSS;
			bo_ctrl2_q <= RST_ZERO;
			rdata_q <= RST_ZERO;
		end else begin
			nearest_q <= nearest_d;
			bw_mode_q <= bw_mode_d;
			bo_ctrl_q <= bo_ctrl_d;
			mon_sel_q <= mon_sel_d;
			locked_bw_q <= locked_bw_d;
			acq_bw_q <= acq_bw_d;
			damping_q <= damping_d;
			pd2_q <= pd2_d;
			adj_lo_q <= adj_lo_d;
			adj_hi_q <= adj_hi_d;
			mean_q <= mean_d;
			fine_q <= fine_d;
			coarse_q <= coarse_d;
			bo_ctrl2_q <= bo_ctrl2_d;
			rdata_q <= rdata_d;
		end
	end

	// Build-out sequencing, input selection and phase outputs.
	always_comb begin
		wr_bo = reg_wr_i && (reg_addr_i == ADDR_BUILD_OUT_CTRL);
		enable_rise = wr_bo && reg_wdata_i[BIT_BO_ENABLE] && !bo_ctrl_q[BIT_BO_ENABLE];
		disable_fall = wr_bo && !reg_wdata_i[BIT_BO_ENABLE] && bo_ctrl_q[BIT_BO_ENABLE];
		mean_mag = mean_q[5] ? 6'(-mean_q[5:0]) : mean_q[5:0];
		if (mean_mag > MEAN_LIMIT_STEPS) begin
			mean_mag = MEAN_LIMIT_STEPS;
		end
		mean_ext = mean_q[5] ? 16'(-{10'h000, mean_mag}) : {10'h000, mean_mag};
		sel_d = sel_q;
		if (ref_lost_i) begin
			for (int i = INPUTS - 1; i >= 0; i--) begin
				if (input_avail_i[i] && (SEL_W'(i) != sel_q)) begin
					sel_d = SEL_W'(i);
				end
			end
		end
		event_req = (ref_lost_i && bo_ctrl_q[BIT_BO_ENABLE])
			|| (enable_rise && !lost);
		bo_state_d = bo_state_q;
		offset_d = offset_q;
		holdover_d = holdover_q;
		unique case (bo_state_q)
			BO_IDLE: begin
				if (event_req && !bo_ctrl_q[BIT_BO_FREEZE]) begin
					bo_state_d = BO_MEASURE;
					holdover_d = 1'b1;
				end
			end
			BO_MEASURE: begin
				if (meas_valid_i) begin
					bo_state_d = BO_IDLE;
					holdover_d = 1'b0;
					offset_d = 16'(meas_phase_i + mean_ext);
				end
			end
			default: begin
				bo_state_d = BO_IDLE;
				holdover_d = 1'b0;
			end
		endcase
		if (disable_fall) begin
			bo_state_d = BO_IDLE;
			holdover_d = 1'b0;
			offset_d = 16'h0000;
		end
		adjust_d = (!bo_ctrl_q[BIT_BO_FREEZE] && !bo_ctrl2_q[BIT_BO_OFF2])
			? {adj_hi_q, adj_lo_q} : 16'h0000;
		nearest_out_d = !lost && !coarse_q[BIT_MULTI_CYCLE]
			&& !nearest_q[BIT_NEAREST_DIS];
		if (bw_mode_q[BIT_AUTO_BW] && lost) begin
			bw_d = acq_bw_q[1:0];
		end else begin
			bw_d = locked_bw_q[1:0];
		end
		unique case (fb_type_i)
			FB_ANALOG_HIGH: pd2_gain_d = pd2_q[6:4];
			FB_ANALOG_8K: pd2_gain_d = damping_q[2:0];
			default: pd2_gain_d = pd2_q[2:0];
		endcase
		if (!pd2_q[BIT_PD2_EN]) begin
			pd2_gain_d = 3'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			bo_state_q <= BO_IDLE;
			sel_q <= '0;
			offset_q <= 16'h0000;
			adjust_q <= 16'h0000;
			holdover_q <= 1'b0;
			nearest_out_q <= 1'b0;
			bw_q <= BW_70HZ;
			pd2_gain_q <= 3'h0;
		end else begin
			bo_state_q <= bo_state_d;
			sel_q <= sel_d;
			offset_q <= offset_d;
			adjust_q <= adjust_d;
			holdover_q <= holdover_d;
			nearest_out_q <= nearest_out_d;
			bw_q <= bw_d;
			pd2_gain_q <= pd2_gain_d;
		end
	end

	// The lost flag already leaves a flop; config bits leave their registers.
	assign reg_rdata_o = rdata_q;
	assign phase_lost_o = lost;
	assign nearest_edge_o = nearest_out_q;
	assign bandwidth_o = bw_q;
	assign damping_o = damping_q[2:0];
	assign multi_cycle_o = coarse_q[BIT_MULTI_CYCLE];
	assign coarse_in_loop_o = coarse_q[BIT_COARSE_IN_LOOP];
	assign integral_limit_o = bw_mode_q[BIT_INTEGRAL_LIM];
	assign anti_noise_o = bo_ctrl2_q[BIT_ANTI_NOISE];
	assign pd2_enable_o = pd2_q[BIT_PD2_EN];
	assign pd2_gain_o = pd2_gain_q;
	assign sel_input_o = sel_q;
	assign holdover_o = holdover_q;
	assign build_out_offset_o = offset_q;
	assign feedback_adjust_o = adjust_q;

endmodule // loop_lock_build_out

// *** tb/loop_lock_checker.sv ***
`timescale 1ns/1ps
module loop_lock_checker
	import loop_ctrl_pkg::*;
#(
	parameter int INPUTS = 3,
	parameter int SEL_W = 2
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] fine_phase_mag_i,
	input wire logic [13:0] slip_cycles_i,
	input wire logic at_freq_limit_i,
	input wire logic input_active_i,
	input wire logic ref_lost_i,
	input wire logic [INPUTS-1:0] input_avail_i,
	input wire logic meas_valid_i,
	input wire logic phase_lost_o,
	input wire logic nearest_edge_o,
	input wire logic [1:0] bandwidth_o,
	input wire logic [SEL_W-1:0] sel_input_o,
	input wire logic holdover_o,
	input wire logic [15:0] build_out_offset_o
);
	logic [7:0] bo_q;
	logic [7:0] fl_q;
	logic fine_hit;
	logic [INPUTS-1:0] cur_bit;
	assign fine_hit = fl_q[7] && (fine_phase_mag_i > {5'h00, fl_q[2:0]});
	assign cur_bit = INPUTS'(1) << sel_input_o;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			bo_q <= RST_BUILD_OUT_CTRL;
			fl_q <= RST_FINE_LOSS;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_BUILD_OUT_CTRL) bo_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_FINE_LOSS) fl_q <= reg_wdata_i;
		end
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_trigger;
		ref_lost_i && bo_q[BIT_BO_ENABLE] && !bo_q[BIT_BO_FREEZE] && !holdover_o && !reg_wr_i;
	endsequence
	sequence s_measured;
		holdover_o && meas_valid_i;
	endsequence
	a_reset_state: assert property (disable iff (1'b0) !resetn_i |=>
		phase_lost_o && !nearest_edge_o && bandwidth_o == BW_70HZ && !holdover_o)
		else $error("reset state wrong");
	a_loss_sets: assert property (!reg_wr_i && fine_hit |=> phase_lost_o)
		else $error("loss not raised");
	a_loss_clears: assert property (!reg_wr_i && !fine_hit && !at_freq_limit_i &&
		input_active_i && slip_cycles_i == 14'h0000 |=> !phase_lost_o)
		else $error("loss not cleared");
	a_nearest_off: assert property (phase_lost_o |=> !nearest_edge_o)
		else $error("nearest edge while lost");
	a_bo_start: assert property (s_trigger |=> holdover_o)
		else $error("no holdover on event");
	a_bo_frozen: assert property (ref_lost_i && bo_q[BIT_BO_FREEZE] && !holdover_o &&
		!reg_wr_i |=> !holdover_o)
		else $error("event taken while frozen");
	a_bo_finish: assert property (s_measured |=> !holdover_o)
		else $error("holdover not ended");
	a_bo_disable: assert property (reg_wr_i && reg_addr_i == ADDR_BUILD_OUT_CTRL &&
		!reg_wdata_i[BIT_BO_ENABLE] |=> !holdover_o && build_out_offset_o == 16'h0000)
		else $error("offset not cleared");
	a_sel_moves: assert property (ref_lost_i && |(input_avail_i & ~cur_bit) |=>
		sel_input_o != $past(sel_input_o))
		else $error("input not switched");
endmodule // loop_lock_checker

bind loop_lock_build_out loop_lock_checker #(.INPUTS(INPUTS), .SEL_W(SEL_W)) loop_lock_checker_inst (
	.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .fine_phase_mag_i,
	.slip_cycles_i, .at_freq_limit_i, .input_active_i, .ref_lost_i, .input_avail_i,
	.meas_valid_i, .phase_lost_o, .nearest_edge_o, .bandwidth_o, .sel_input_o, .holdover_o,
	.build_out_offset_o);

// *** tb/ref_source_model.sv ***
`timescale 1ns/1ps
module ref_source_model (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic switch_i,
	input wire logic slow_i,
	input wire logic hold_i,
	input wire logic [15:0] phase_i,
	output logic ref_lost_o,
	output logic meas_valid_o,
	output logic [15:0] meas_phase_o
);
	int cnt = 0;
	always @(posedge core_clk_i) begin
		ref_lost_o <= switch_i && resetn_i;
		meas_valid_o <= 1'b0;
		meas_phase_o <= resetn_i ? ~meas_phase_o : 16'h0000;
		cnt <= hold_i ? cnt + 1 : 0;
		if (hold_i && cnt == (slow_i ? 6 : 1)) begin
			meas_valid_o <= 1'b1;
			meas_phase_o <= phase_i;
		end
	end
endmodule // ref_source_model

// *** tb/loop_lock_build_out_tb.sv ***
`timescale 1ns/1ps
module loop_lock_build_out_tb;
	import loop_ctrl_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic w;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] fine_phase_mag_i = 8'h00;
	logic [13:0] slip_cycles_i = 14'h0000;
	logic at_freq_limit_i = 1'b0;
	logic input_active_i = 1'b1;
	logic [2:0] input_avail_i = 3'h7;
	logic [15:0] primary_phase_i = 16'h5a3c;
	logic [15:0] secondary_phase_i = 16'hc30f;
	logic [1:0] fb_type_i = FB_DIGITAL;
	logic sw = 1'b0;
	logic slow = 1'b0;
	logic [15:0] phase = 16'h0100;
	logic ref_lost_i, meas_valid_i, phase_lost_o, nearest_edge_o, multi_cycle_o;
	logic integral_limit_o, pd2_enable_o, holdover_o, coarse_in_loop_o, anti_noise_o;
	logic [15:0] meas_phase_i, build_out_offset_o, feedback_adjust_o;
	logic [7:0] reg_rdata_o;
	logic [1:0] bandwidth_o, sel_input_o;
	logic [2:0] damping_o, pd2_gain_o;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	row_t rows [16] = '{
		'{8'h48, 1'b0, 8'h00, 8'h08},
		'{8'h73, 1'b0, 8'h00, 8'he2},
		'{8'h3b, 1'b1, 8'h88, 8'h88},
		'{8'h67, 1'b1, 8'h00, 8'h00},
		'{8'h69, 1'b1, 8'h01, 8'h01},
		'{8'h6b, 1'b1, 8'h05, 8'h05},
		'{8'h6d, 1'b1, 8'hd3, 8'hd3},
		'{8'h70, 1'b1, 8'h34, 8'h34},
		'{8'h71, 1'b1, 8'h12, 8'h12},
		'{8'h72, 1'b1, 8'h05, 8'h05},
		'{8'h74, 1'b1, 8'h01, 8'h01},
		'{8'h00, 1'b1, 8'hff, 8'h00},
		'{8'h77, 1'b1, 8'haa, 8'h3c},
		'{8'h78, 1'b0, 8'h00, 8'h5a},
		'{8'h4b, 1'b1, 8'h10, 8'h10},
		'{8'h77, 1'b0, 8'h00, 8'h0f}
	};
	loop_lock_build_out loop_lock_build_out_inst (.core_clk_i, .resetn_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fine_phase_mag_i, .slip_cycles_i,
		.at_freq_limit_i, .input_active_i, .ref_lost_i, .input_avail_i, .meas_valid_i,
		.meas_phase_i, .primary_phase_i, .secondary_phase_i, .fb_type_i, .phase_lost_o,
		.nearest_edge_o, .bandwidth_o, .damping_o, .multi_cycle_o, .coarse_in_loop_o,
		.integral_limit_o, .anti_noise_o, .pd2_enable_o, .pd2_gain_o, .sel_input_o,
		.holdover_o, .build_out_offset_o, .feedback_adjust_o);
	ref_source_model ref_source_model_inst (.core_clk_i, .resetn_i, .switch_i(sw),
		.slow_i(slow), .hold_i(holdover_o), .phase_i(phase), .ref_lost_o(ref_lost_i),
		.meas_valid_o(meas_valid_i), .meas_phase_o(meas_phase_i));
	always #5 core_clk_i = ~core_clk_i;
	task step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		step(1);
		reg_wr_i = 1'b0;
		step(1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		step(1);
		reg_rd_i = 1'b0;
		step(1);
		chk("read data", {8'h00, e}, {8'h00, reg_rdata_o});
	endtask
	task wait_hold(input logic lv, input int lim);
		int n;
		n = 0;
		while (holdover_o !== lv && n < lim) begin
			step(1);
			n++;
		end
		chk("holdover", {15'h0000, lv}, {15'h0000, holdover_o});
	endtask
	task give_verdict;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		step(2);
		resetn_i = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk("damping", 16'h0005, 16'(damping_o));
		chk("pd2 gain", 16'h0003, 16'(pd2_gain_o));
		fb_type_i = FB_ANALOG_HIGH;
		step(2);
		chk("pd2 gain", 16'h0005, 16'(pd2_gain_o));
		chk("pd2 enable", 16'h0001, 16'(pd2_enable_o));
		wr(ADDR_PD2_GAIN, 8'h53);
		chk("pd2 gain", 16'h0000, 16'(pd2_gain_o));
		chk("pd2 enable", 16'h0000, 16'(pd2_enable_o));
		chk("integral", 16'h0001, 16'(integral_limit_o));
		chk("bandwidth", 16'(BW_18HZ), 16'(bandwidth_o));
		chk("nearest", 16'h0001, 16'(nearest_edge_o));
		chk("adjust", 16'h1234, feedback_adjust_o);
		at_freq_limit_i = 1'b1;
		step(3);
		chk("lost", 16'h0001, 16'(phase_lost_o));
		chk("bandwidth", 16'(BW_35HZ), 16'(bandwidth_o));
		wr(ADDR_FINE_LOSS, 8'ha2);
		step(2);
		chk("lost", 16'h0000, 16'(phase_lost_o));
		fine_phase_mag_i = 8'h02;
		step(3);
		chk("lost", 16'h0000, 16'(phase_lost_o));
		fine_phase_mag_i = 8'h03;
		step(3);
		chk("lost", 16'h0001, 16'(phase_lost_o));
		wr(ADDR_BW_MODE, 8'h00);
		chk("bandwidth", 16'(BW_18HZ), 16'(bandwidth_o));
		wr(ADDR_BW_MODE, 8'h80);
		fine_phase_mag_i = 8'h00;
		at_freq_limit_i = 1'b0;
		wr(ADDR_COARSE_LOSS, 8'hc1);
		slip_cycles_i = 14'h0002;
		step(3);
		chk("lost", 16'h0000, 16'(phase_lost_o));
		chk("nearest", 16'h0000, 16'(nearest_edge_o));
		chk("multi cycle", 16'h0001, 16'(multi_cycle_o));
		slip_cycles_i = 14'h0003;
		step(3);
		chk("lost", 16'h0001, 16'(phase_lost_o));
		slip_cycles_i = 14'h0000;
		wr(ADDR_COARSE_LOSS, 8'h21);
		step(3);
		chk("multi cycle", 16'h0000, 16'(multi_cycle_o));
		chk("coarse in loop", 16'h0001, 16'(coarse_in_loop_o));
		sw = 1'b1;
		step(1);
		sw = 1'b0;
		wait_hold(1'b1, 10);
		chk("input", 16'h0001, 16'(sel_input_o));
		wait_hold(1'b0, 20);
		chk("offset", 16'h0105, build_out_offset_o);
		wr(ADDR_MEAN_OFFSET, 8'h1f);
		wr(ADDR_BUILD_OUT_CTRL, 8'h00);
		chk("offset", 16'h0000, build_out_offset_o);
		slow = 1'b1;
		phase = 16'h0200;
		wr(ADDR_BUILD_OUT_CTRL, 8'h08);
		wait_hold(1'b1, 3);
		wait_hold(1'b0, 20);
		chk("offset", 16'h0200 + 16'(MEAN_LIMIT_STEPS), build_out_offset_o);
		wr(ADDR_BUILD_OUT_CTRL, 8'h0c);
		sw = 1'b1;
		step(1);
		sw = 1'b0;
		step(3);
		wait_hold(1'b0, 4);
		chk("input", 16'h0000, 16'(sel_input_o));
		chk("offset", 16'h0200 + 16'(MEAN_LIMIT_STEPS), build_out_offset_o);
		chk("adjust", 16'h0000, feedback_adjust_o);
		wr(ADDR_BUILD_OUT_CTRL2, 8'h90);
		wr(ADDR_BUILD_OUT_CTRL, 8'h00);
		step(1);
		chk("adjust", 16'h0000, feedback_adjust_o);
		chk("anti noise", 16'h0001, 16'(anti_noise_o));
		resetn_i = 1'b0;
		step(2);
		chk("lost", 16'h0001, 16'(phase_lost_o));
		chk("bandwidth", 16'(BW_70HZ), 16'(bandwidth_o));
		chk("holdover", 16'h0000, 16'(holdover_o));
		chk("anti noise", 16'h0000, 16'(anti_noise_o));
		resetn_i = 1'b1;
		rd(ADDR_BUILD_OUT_CTRL, RST_BUILD_OUT_CTRL);
		give_verdict();
	end
endmodule // loop_lock_build_out_tb
